// file: rtl/olap_defs.svh
// Constants shared by both ends of the optical link access port.
// Assumes inclusion by bare name; definitions only.
`ifndef OLAP_DEFS_SVH
`define OLAP_DEFS_SVH

// Clock and nominal link rate, one beat per clock
`define OLAP_CLK_MHZ       10
`define OLAP_LINK_MBPS     80
`define OLAP_BEAT_BYTES    (`OLAP_LINK_MBPS / `OLAP_CLK_MHZ)
`define OLAP_WORD_BYTES    4
`define OLAP_WORD_STEP     32'h0000_0004
`define OLAP_MAX_BOARDS    8

// Control register bit that lets the board broadcast its interrupt
`define OLAP_CTRL_IRQ_BIT  3
// Only this bit of the reported active-interrupt mask is meaningful
`define OLAP_IRQ_CHECK_BIT 0

// Address modifiers; the supervisory bit is masked off before decode
`define OLAP_AM_CLASS_MASK 6'h3b
`define OLAP_AM_A32_SGL    6'h09
`define OLAP_AM_A32_BLT    6'h0b
`define OLAP_AM_A32_MBLT   6'h08
`define OLAP_AM_A24_SGL    6'h39
`define OLAP_AM_A24_BLT    6'h3b
`define OLAP_AM_A24_MBLT   6'h38

// Host gives up on an access nobody answers after this many cycles
`define OLAP_TMO_CYCLES    1000

`endif

// file: rtl/olap_pkg.sv
// Types of the optical link access port.
// Assumes olap_defs.svh is on the include path.
`include "olap_defs.svh"

package olap_pkg;

    typedef enum logic [1:0] {
        OLAP_OP_READ, OLAP_OP_BLT, OLAP_OP_WRITE, OLAP_OP_BLKWR
    } olap_op_t;

    typedef enum logic [1:0] {
        OLAP_DW_D16, OLAP_DW_D32, OLAP_DW_D64
    } olap_dw_t;

    typedef enum logic [1:0] {
        OLAP_AMK_SGL, OLAP_AMK_BLT, OLAP_AMK_MBLT, OLAP_AMK_BAD
    } olap_amk_t;

    // Cycle class of an address modifier, supervisory bit ignored
    function automatic olap_amk_t olap_am_kind(input logic [5:0] am);
        logic [5:0] c;
        c = am & `OLAP_AM_CLASS_MASK;
        case (c)
            `OLAP_AM_A32_SGL, `OLAP_AM_A24_SGL:   return OLAP_AMK_SGL;
            `OLAP_AM_A32_BLT, `OLAP_AM_A24_BLT:   return OLAP_AMK_BLT;
            `OLAP_AM_A32_MBLT, `OLAP_AM_A24_MBLT: return OLAP_AMK_MBLT;
            default:                              return OLAP_AMK_BAD;
        endcase
    endfunction

endpackage

// file: rtl/olap_if.sv
// Optical link between a host link controller and one chain of boards.
// Assumes both ends share i_clk; the bench joins the two ends here.
`timescale 1ns/1ps

interface olap_if import olap_pkg::*; ();
    // Host to board: access request, held until done
    logic        req;
    olap_op_t    op;
    logic [2:0]  brd;
    logic [5:0]  am;
    logic [31:0] addr;
    olap_dw_t    dw;
    logic        fifo;
    logic [31:0] wdata;
    logic [15:0] len;
    logic        rd_ready;
    // Board to host: answer and interrupt
    logic        done;
    logic        berr;
    logic        rvalid;
    logic [63:0] rdata;
    logic        irq;

    modport dev (input  req, op, brd, am, addr, dw, fifo, wdata, len,
                 input  rd_ready,
                 output done, berr, rvalid, rdata, irq);
    modport host (output req, op, brd, am, addr, dw, fifo, wdata, len,
                  output rd_ready,
                  input  done, berr, rvalid, rdata, irq);
endinterface

// file: rtl/olap_arb.sv
// Two-way arbiter for the board's internal controller.
// Assumes each requester holds its request for as long as it needs it.
`timescale 1ns/1ps

module olap_arb (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_req_vme,
    input  wire logic i_req_link,
    output logic      o_gnt_vme,
    output logic      o_gnt_link
);
    logic keep_vme;
    logic keep_link;
    logic next_vme;
    logic next_link;

    // An owner keeps the grant while it requests; ties go to the VME path
    assign keep_vme  = o_gnt_vme & i_req_vme;
    assign keep_link = o_gnt_link & i_req_link;
    assign next_vme  = keep_vme | (~keep_link & i_req_vme);
    assign next_link = keep_link | (~keep_vme & ~i_req_vme & i_req_link);

    // Grant register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_gnt_vme  <= 1'b0;
            o_gnt_link <= 1'b0;
        end else begin
            o_gnt_vme  <= next_vme;
            o_gnt_link <= next_link;
        end
    end
endmodule // olap_arb

// file: rtl/olap_dev.sv
// Board end of the optical link access port.
// Assumes the internal controller answers each word with one ack pulse
// and that VME path fields are steady while its request is high.
//
// How it works
// - One 64-bit beat per four clocks at best, chainable boards
// - Answer only accesses with own chain position
// - Single read, block read, single write only
// - Mismatched modifier, base or width gives error
// - Broadcast interrupt only when control bit 3
// - Host forwards interrupt on o_irq only for enabled link
// - VME path wins ties for the internal controller
// - Masters avoid VME and link access together
// - Non-incrementing block read keeps one address
// - Block reads support 64-bit multiplexed beats
// - Only bit 0 of active mask matters
// - Byte-counted block read, may end early
`timescale 1ns/1ps

module olap_dev import olap_pkg::*; #(
    parameter logic [2:0]  BRD_POS = 3'h0,
    parameter logic [15:0] BASE    = 16'h0001
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    olap_if.dev              link,
    input  wire logic [31:0] i_vme_ctrl,
    input  wire logic        i_irq_pend,
    input  wire logic        i_vme_req,
    input  wire logic        i_vme_we,
    input  wire logic [15:0] i_vme_addr,
    input  wire logic [31:0] i_vme_wdata,
    output logic             o_vme_gnt,
    output logic             o_vme_ack,
    output logic             o_vme_berr,
    output logic [31:0]      o_vme_rdata,
    output logic             o_ctl_req,
    output logic             o_ctl_we,
    output logic [15:0]      o_ctl_addr,
    output logic [31:0]      o_ctl_wdata,
    input  wire logic        i_ctl_ack,
    input  wire logic        i_ctl_berr,
    input  wire logic [31:0] i_ctl_rdata
);
    typedef enum {
        ST_IDLE, ST_CHECK, ST_RD, ST_SEND, ST_WR, ST_FIN, ST_DROP
    } olap_st_t;

    olap_st_t    st;
    olap_op_t    op;
    olap_dw_t    dw;
    logic [5:0]  am;
    logic [31:0] addr;
    logic        fifo;
    logic [31:0] wdata;
    logic [15:0] len;
    logic [15:0] bytes;
    logic        half;
    logic        err;
    logic [63:0] rdata;
    logic        irq;

    logic        gnt_vme;
    logic        gnt_link;
    logic        sel;
    olap_amk_t   amk;
    logic        a32;
    logic        base_ok;
    logic        kind_ok;
    logic        params_ok;
    logic        link_req;
    logic        ctl_go;
    logic        need_hi;
    logic [15:0] beat_bytes;
    logic [16:0] bytes_after;
    logic        last_beat;
    logic [31:0] next_addr;

    // Shared controller access; VME and link requests are separate paths
    olap_arb u_arb (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_req_vme  (i_vme_req),
        .i_req_link (link_req),
        .o_gnt_vme  (gnt_vme),
        .o_gnt_link (gnt_link)
    );

    // Address decode: an access for another board is left to that board
    assign sel = link.req & (link.brd == BRD_POS);

    // Parameter checks on the latched access, as the VME slave does them
    assign amk     = olap_am_kind(am);
    assign a32     = (am[5:4] == 2'b00);
    assign base_ok = a32 ? (addr[31:16] == BASE)
                         : (addr[31:24] == 8'h00 &&
                            addr[23:16] == BASE[7:0]);
    // Block write has no legal combination and is always refused
    assign kind_ok = ((op == OLAP_OP_READ || op == OLAP_OP_WRITE) &&
                      amk == OLAP_AMK_SGL && dw == OLAP_DW_D32) ||
                     (op == OLAP_OP_BLT &&
                      ((amk == OLAP_AMK_BLT && dw == OLAP_DW_D32) ||
                       (amk == OLAP_AMK_MBLT && dw == OLAP_DW_D64)));
    assign params_ok = base_ok & kind_ok;

    // Word-level progress of a link access on the internal controller
    assign link_req  = (st == ST_RD) || (st == ST_WR);
    assign ctl_go    = gnt_link & link_req & i_ctl_ack;
    assign need_hi   = (dw == OLAP_DW_D64) & ~half;
    assign beat_bytes = (dw == OLAP_DW_D64) ? 16'(`OLAP_BEAT_BYTES)
                                            : 16'(`OLAP_WORD_BYTES);
    assign bytes_after = {1'b0, bytes} + {1'b0, beat_bytes};
    assign last_beat   = (bytes_after >= {1'b0, len});
    // Readout FIFO reads stay on one address for the whole block
    assign next_addr = fifo ? addr : addr + `OLAP_WORD_STEP;

    // Access sequencer
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st    <= ST_IDLE;
            op    <= OLAP_OP_READ;
            dw    <= OLAP_DW_D32;
            am    <= 6'h00;
            addr  <= 32'h0000_0000;
            fifo  <= 1'b0;
            wdata <= 32'h0000_0000;
            len   <= 16'h0000;
            bytes <= 16'h0000;
            half  <= 1'b0;
            err   <= 1'b0;
            rdata <= 64'h0000_0000_0000_0000;
        end else begin
            unique case (st)
                ST_IDLE: begin
                    if (sel) begin
                        op    <= link.op;
                        dw    <= link.dw;
                        am    <= link.am;
                        addr  <= link.addr;
                        fifo  <= link.fifo;
                        wdata <= link.wdata;
                        len   <= link.len;
                        bytes <= 16'h0000;
                        half  <= 1'b0;
                        err   <= 1'b0;
                        st    <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (!params_ok) begin
                        err <= 1'b1;
                        st  <= ST_FIN;
                    end else if (op == OLAP_OP_WRITE) begin
                        st <= ST_WR;
                    end else begin
                        st <= ST_RD;
                    end
                end
                ST_RD: begin
                    if (ctl_go) begin
                        addr <= next_addr;
                        if (i_ctl_berr) begin
                            // Readout ran dry: end early, host counts bytes
                            err <= 1'b1;
                            st  <= ST_FIN;
                        end else if (need_hi) begin
                            rdata <= {32'h0000_0000, i_ctl_rdata};
                            half  <= 1'b1;
                        end else begin
                            if (half) begin
                                rdata[63:32] <= i_ctl_rdata;
                            end else begin
                                rdata <= {32'h0000_0000, i_ctl_rdata};
                            end
                            half <= 1'b0;
                            st   <= (op == OLAP_OP_READ) ? ST_FIN : ST_SEND;
                        end
                    end
                end
                ST_SEND: begin
                    if (link.rd_ready) begin
                        bytes <= bytes_after[15:0];
                        st    <= last_beat ? ST_FIN : ST_RD;
                    end
                end
                ST_WR: begin
                    if (ctl_go) begin
                        err <= i_ctl_berr;
                        st  <= ST_FIN;
                    end
                end
                ST_FIN: begin
                    st <= ST_DROP;
                end
                ST_DROP: begin
                    // Wait for the host to drop the request, else it repeats
                    if (!link.req) begin
                        st <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Link answer; a beat leaves at best every third clock for 32-bit and every fourth for 64-bit, below full rate
    assign link.done   = (st == ST_FIN);
    assign link.berr   = (st == ST_FIN) & err;
    assign link.rvalid = (st == ST_SEND);
    assign link.rdata  = rdata;
    assign link.irq    = irq;

    // Interrupt level follows the pending condition while enabled
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= i_irq_pend & i_vme_ctrl[`OLAP_CTRL_IRQ_BIT];
        end
    end

    // Internal controller steering; VME data flows only while it holds grant
    assign o_ctl_req   = (gnt_vme & i_vme_req) | (gnt_link & link_req);
    assign o_ctl_we    = gnt_vme ? i_vme_we : (st == ST_WR);
    assign o_ctl_addr  = gnt_vme ? i_vme_addr : addr[15:0];
    assign o_ctl_wdata = gnt_vme ? i_vme_wdata : wdata;
    assign o_vme_gnt   = gnt_vme;
    assign o_vme_ack   = gnt_vme & i_vme_req & i_ctl_ack;
    assign o_vme_berr  = gnt_vme & i_vme_req & i_ctl_ack & i_ctl_berr;

    // VME read data is held from the ack until the next VME ack
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_vme_rdata <= 32'h0000_0000;
        end else if (o_vme_ack) begin
            o_vme_rdata <= i_ctl_rdata;
        end
    end
endmodule // olap_dev

// file: rtl/olap_host.sv
// Host link controller end of the optical link access port.
// Assumes one command at a time from the host software side.
`timescale 1ns/1ps

module olap_host import olap_pkg::*; #(
    parameter int         TMO_CYCLES = `OLAP_TMO_CYCLES,
    parameter logic [2:0] LINK_IDX   = 3'h0
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    olap_if.host             link,
    input  wire logic        i_cmd_valid,
    output logic             o_cmd_ready,
    input  wire olap_op_t    i_cmd_op,
    input  wire logic [2:0]  i_cmd_brd,
    input  wire logic [5:0]  i_cmd_am,
    input  wire logic [31:0] i_cmd_addr,
    input  wire olap_dw_t    i_cmd_dw,
    input  wire logic        i_cmd_fifo,
    input  wire logic [31:0] i_cmd_wdata,
    input  wire logic [15:0] i_cmd_len,
    input  wire logic        i_data_ready,
    output logic             o_data_valid,
    output logic [63:0]      o_data,
    output logic             o_done,
    output logic             o_err,
    output logic             o_timeout,
    output logic [15:0]      o_count,
    input  wire logic [7:0]  i_irq_en,
    output logic [7:0]       o_irq_check,
    output logic             o_irq
);
    localparam int TW = $clog2(TMO_CYCLES + 1);

    typedef enum {HS_IDLE, HS_BUSY, HS_END} olap_hst_t;

    olap_hst_t   st;
    olap_op_t    op;
    olap_dw_t    dw;
    logic [2:0]  brd;
    logic [5:0]  am;
    logic [31:0] addr;
    logic        fifo;
    logic [31:0] wdata;
    logic [15:0] len;
    logic [TW-1:0] tmo;
    logic        take;
    logic        beat;
    logic        expired;

    assign take    = (st == HS_IDLE) & i_cmd_valid;
    assign beat    = link.rvalid & link.rd_ready;
    assign expired = (tmo == TW'(TMO_CYCLES));

    // Access fields stay fixed for the whole transfer
    assign link.req      = (st == HS_BUSY);
    assign link.op       = op;
    assign link.brd      = brd;
    assign link.am       = am;
    assign link.addr     = addr;
    assign link.dw       = dw;
    assign link.fifo     = fifo;
    assign link.wdata    = wdata;
    assign link.len      = len;
    assign link.rd_ready = (st == HS_BUSY) & i_data_ready;
    assign o_cmd_ready   = (st == HS_IDLE);
    assign o_done        = (st == HS_END);

    // Command sequencer with a watchdog for unanswered accesses
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st           <= HS_IDLE;
            op           <= OLAP_OP_READ;
            dw           <= OLAP_DW_D32;
            brd          <= 3'h0;
            am           <= 6'h00;
            addr         <= 32'h0000_0000;
            fifo         <= 1'b0;
            wdata        <= 32'h0000_0000;
            len          <= 16'h0000;
            tmo          <= '0;
            o_err        <= 1'b0;
            o_timeout    <= 1'b0;
            o_count      <= 16'h0000;
            o_data       <= 64'h0000_0000_0000_0000;
            o_data_valid <= 1'b0;
        end else begin
            o_data_valid <= 1'b0;
            unique case (st)
                HS_IDLE: begin
                    if (take) begin
                        op        <= i_cmd_op;
                        dw        <= i_cmd_dw;
                        brd       <= i_cmd_brd;
                        am        <= i_cmd_am;
                        addr      <= i_cmd_addr;
                        fifo      <= i_cmd_fifo;
                        wdata     <= i_cmd_wdata;
                        len       <= i_cmd_len;
                        tmo       <= '0;
                        o_err     <= 1'b0;
                        o_timeout <= 1'b0;
                        o_count   <= 16'h0000;
                        st        <= HS_BUSY;
                    end
                end
                HS_BUSY: begin
                    tmo <= beat ? '0 : tmo + TW'(1);
                    if (beat) begin
                        // Count bytes actually received
                        o_count <= o_count + ((dw == OLAP_DW_D64)
                                   ? 16'(`OLAP_BEAT_BYTES)
                                   : 16'(`OLAP_WORD_BYTES));
                        o_data       <= link.rdata;
                        o_data_valid <= 1'b1;
                    end
                    if (link.done) begin
                        o_err <= link.berr;
                        if (op == OLAP_OP_READ && !link.berr) begin
                            o_data       <= link.rdata;
                            o_data_valid <= 1'b1;
                        end
                        st <= HS_END;
                    end else if (expired) begin
                        o_err     <= 1'b1;
                        o_timeout <= 1'b1;
                        st        <= HS_END;
                    end
                end
                HS_END: begin
                    st <= HS_IDLE;
                end
            endcase
        end
    end

    // Interrupt forwarding on o_irq gated by this link's enable bit; o_irq_check reports the link ungated
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_irq       <= 1'b0;
            o_irq_check <= 8'h00;
        end else begin
            o_irq <= link.irq & i_irq_en[LINK_IDX];
            o_irq_check <= 8'h00;
            o_irq_check[`OLAP_IRQ_CHECK_BIT] <= link.irq;
        end
    end
endmodule // olap_host

// file: testbench/olap_sva.sv
// Checker on the link between the host and board ends.
// Assumes the bench wires it to the link interface by name.
`timescale 1ns/1ps

module olap_sva import olap_pkg::*; #(
    parameter logic [2:0] BRD_POS = 3'h0
) (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        req,
    input wire olap_op_t    op,
    input wire logic [2:0]  brd,
    input wire logic [31:0] addr,
    input wire olap_dw_t    dw,
    input wire logic        rd_ready,
    input wire logic        done,
    input wire logic        berr,
    input wire logic        rvalid,
    input wire logic [63:0] rdata
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Refused kind of access, seen as it starts
    sequence s_blkwr_taken;
        $rose(req) && op == OLAP_OP_BLKWR && brd == BRD_POS;
    endsequence

    chk_blkwr_refused: assert property (
        s_blkwr_taken |-> ##[1:4] (done && berr))
        else $error("block write not answered with error");
    chk_beat_in_access: assert property (rvalid |-> req)
        else $error("beat offered outside an access");
    chk_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    chk_done_own: assert property (
        done |-> req && brd == BRD_POS)
        else $error("answer to another position");
    chk_wrong_brd: assert property (
        req && brd != BRD_POS |-> !done && !rvalid)
        else $error("board answered foreign access");
    chk_berr_done: assert property (berr |-> done)
        else $error("error flag without done");
    chk_width_err: assert property (
        done && op == OLAP_OP_READ && dw != OLAP_DW_D32 |-> berr)
        else $error("bad width accepted");
    chk_beat_hold: assert property (
        rvalid && !rd_ready |=> rvalid && $stable(rdata))
        else $error("beat dropped before accepted");
    chk_fixed_addr: assert property (
        req && !done |=> $stable({addr, op}))
        else $error("access fields moved mid access");
endmodule // olap_sva

// file: testbench/optical_link_access_port_bench.sv
// Bench joining host and board ends over one link.
// Assumes a 10 MHz clock; the internal controller is modelled here.
`timescale 1ns/1ps

module optical_link_access_port_bench import olap_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        cmd_valid, cmd_fifo, data_ready, irq_pend, vme_req;
    logic        ctl_ack;
    olap_op_t    cmd_op;
    olap_dw_t    cmd_dw;
    logic [2:0]  cmd_brd;
    logic [5:0]  cmd_am;
    logic [7:0]  irq_en;
    logic [15:0] cmd_len, wr_addr;
    logic [31:0] cmd_addr, cmd_wdata, vme_ctrl, ctl_rdata, wr_data;
    logic        cmd_ready, data_valid, h_done, h_err, h_tmo, h_irq;
    logic        vme_ack, ctl_req, ctl_we;
    logic [63:0] h_data;
    logic [15:0] h_count, ctl_addr;
    logic [31:0] ctl_wdata, vme_rdata;
    logic [7:0]  irq_check;
    logic [63:0] beats[$];
    int          failures = 0;
    int          checks_done = 0;
    int          seed = 32'h74ad;

    always #50 i_clk = ~i_clk;

    olap_if lnk ();
    olap_host #(.TMO_CYCLES(20)) olap_host_i (
        .i_clk, .i_rst, .link(lnk.host), .i_cmd_valid(cmd_valid),
        .o_cmd_ready(cmd_ready), .i_cmd_op(cmd_op), .i_cmd_brd(cmd_brd),
        .i_cmd_am(cmd_am), .i_cmd_addr(cmd_addr), .i_cmd_dw(cmd_dw),
        .i_cmd_fifo(cmd_fifo), .i_cmd_wdata(cmd_wdata), .i_cmd_len(cmd_len),
        .i_data_ready(data_ready), .o_data_valid(data_valid), .o_data(h_data),
        .o_done(h_done), .o_err(h_err), .o_timeout(h_tmo), .o_count(h_count),
        .i_irq_en(irq_en), .o_irq_check(irq_check), .o_irq(h_irq));
    olap_dev olap_dev_i (
        .i_clk, .i_rst, .link(lnk.dev), .i_vme_ctrl(vme_ctrl),
        .i_irq_pend(irq_pend), .i_vme_req(vme_req), .i_vme_we(1'b0),
        .i_vme_addr(16'h0200), .i_vme_wdata(32'h0), .o_vme_gnt(),
        .o_vme_ack(vme_ack), .o_vme_berr(), .o_vme_rdata(vme_rdata),
        .o_ctl_req(ctl_req), .o_ctl_we(ctl_we), .o_ctl_addr(ctl_addr),
        .o_ctl_wdata(ctl_wdata), .i_ctl_ack(ctl_ack),
        .i_ctl_berr(ctl_addr[12]), .i_ctl_rdata(ctl_rdata));
    olap_sva olap_sva_i (
        .i_clk, .i_rst, .req(lnk.req), .op(lnk.op), .brd(lnk.brd),
        .addr(lnk.addr), .dw(lnk.dw), .rd_ready(lnk.rd_ready),
        .done(lnk.done), .berr(lnk.berr), .rvalid(lnk.rvalid),
        .rdata(lnk.rdata));

    // Words echo an address pattern; bit 12 set answers bus error
    function automatic logic [31:0] word_at(input logic [15:0] a);
        return {~a, a};
    endfunction

    // Controller stand-in: one ack every other cycle, so words can stall
    always @(negedge i_clk) begin
        ctl_ack    <= ctl_req & ~ctl_ack;
        ctl_rdata  <= word_at(ctl_addr);
        data_ready <= 1'($random(seed));
    end
    always @(posedge i_clk) begin
        if (ctl_ack === 1'b1 && ctl_we === 1'b1) begin
            wr_addr <= ctl_addr;
            wr_data <= ctl_wdata;
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One host command, beats collected until done
    task automatic go(input olap_op_t op, input logic [5:0] am,
                      input logic [31:0] a, input olap_dw_t dw,
                      input logic f, input logic [15:0] len,
                      input logic [2:0] brd, input logic [31:0] wd);
        int n;
        beats = {};
        for (n = 0; n < 300 && cmd_ready !== 1'b1; n++) @(negedge i_clk);
        cmd_valid <= 1'b1;
        cmd_op    <= op;
        cmd_am    <= am;
        cmd_addr  <= a;
        cmd_dw    <= dw;
        cmd_fifo  <= f;
        cmd_len   <= len;
        cmd_brd   <= brd;
        cmd_wdata <= wd;
        @(negedge i_clk);
        cmd_valid <= 1'b0;
        for (n = 0; n < 300; n++) begin
            @(posedge i_clk);
            #1;
            if (data_valid === 1'b1) beats.push_back(h_data);
            if (h_done === 1'b1) break;
        end
        if (n == 300) begin
            failures++;
            tally_and_finish();
        end
        @(negedge i_clk);
    endtask

    initial begin
        int k;
        logic [31:0] a, d;
        logic [5:0]  am;
        {cmd_valid, cmd_fifo, data_ready, irq_pend, vme_req} = '0;
        {cmd_brd, cmd_am, cmd_len, cmd_addr, cmd_wdata} = '0;
        {ctl_ack, ctl_rdata, vme_ctrl} = '0;
        cmd_op = OLAP_OP_READ;
        cmd_dw = OLAP_DW_D32;
        irq_en = 8'h01;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk) i_rst = 1'b0;
        // Random single writes and reads, A32 and A24, user and supervisor
        for (k = 0; k < 4; k++) begin
            a  = {16'h0001, 16'($random(seed)) & 16'h0ffc};
            d  = $random(seed);
            am = (k[0] ? 6'h39 : 6'h09) | (k[1] ? 6'h04 : 6'h00);
            go(OLAP_OP_WRITE, am, a, OLAP_DW_D32, 1'b0, 16'h4, 3'h0, d);
            check(h_err, 1'b0);
            check({wr_addr, wr_data}, {a[15:0], d});
            go(OLAP_OP_READ, am, a, OLAP_DW_D32, 1'b0, 16'h4, 3'h0, 32'h0);
            check({h_err, h_data[31:0]}, {1'b0, word_at(a[15:0])});
        end
        // Mismatched width, modifier, base, and the refused block write
        a = 32'h0001_0010;
        go(OLAP_OP_READ, 6'h09, a, OLAP_DW_D16, 1'b0, 16'h4, 3'h0, 32'h0);
        check(h_err, 1'b1);
        go(OLAP_OP_READ, 6'h0b, a, OLAP_DW_D32, 1'b0, 16'h4, 3'h0, 32'h0);
        check(h_err, 1'b1);
        go(OLAP_OP_READ, 6'h09, 32'h0002_0010, OLAP_DW_D32, 1'b0, 16'h4,
           3'h0, 32'h0);
        check(h_err, 1'b1);
        go(OLAP_OP_READ, 6'h39, 32'h0101_0010, OLAP_DW_D32, 1'b0, 16'h4,
           3'h0, 32'h0);
        check(h_err, 1'b1);
        go(OLAP_OP_BLT, 6'h0b, a, OLAP_DW_D64, 1'b0, 16'h10, 3'h0, 32'h0);
        check(h_err, 1'b1);
        go(OLAP_OP_BLKWR, 6'h0b, a, OLAP_DW_D32, 1'b0, 16'h8, 3'h0, 32'h0);
        check(h_err, 1'b1);
        // Other chain position: nobody answers
        go(OLAP_OP_READ, 6'h09, a, OLAP_DW_D32, 1'b0, 16'h4, 3'h5, 32'h0);
        check(h_tmo, 1'b1);
        // Incrementing 32-bit block, cut short by bus error
        go(OLAP_OP_BLT, 6'h0b, 32'h0001_0ff0, OLAP_DW_D32, 1'b0, 16'h14,
           3'h0, 32'h0);
        check({h_err, h_count, 16'(beats.size())},
              {1'b1, 16'h10, 16'h4});
        foreach (beats[i]) check(beats[i][31:0], word_at(16'hff0 + 4 * i));
        // Fixed address multiplexed 64-bit block
        go(OLAP_OP_BLT, 6'h08, 32'h0001_0000, OLAP_DW_D64, 1'b1, 16'h18,
           3'h0, 32'h0);
        check({h_count, 16'(beats.size())}, {16'h18, 16'h3});
        foreach (beats[i]) check(beats[i], {2{word_at(16'h0)}});
        // Both paths asking: the VME path is served first
        vme_req = 1'b1;
        fork
            go(OLAP_OP_READ, 6'h09, 32'h0001_0040, OLAP_DW_D32, 1'b0, 16'h4,
               3'h0, 32'h0);
            begin
                for (k = 0; k < 100; k++) begin
                    @(posedge i_clk);
                    #1;
                    if (vme_ack === 1'b1) break;
                end
                check({vme_ack, 16'(beats.size())}, {1'b1, 16'h0});
                @(negedge i_clk) vme_req = 1'b0;
            end
        join
        check({vme_rdata, h_data[31:0]}, {word_at(16'h200), word_at(16'h40)});
        // Interrupt broadcast gated by control bit, then host mask
        irq_pend = 1'b1;
        repeat (4) @(negedge i_clk);
        check({h_irq, irq_check[0]}, 2'b00);
        vme_ctrl = 32'h1 << `OLAP_CTRL_IRQ_BIT;
        repeat (4) @(negedge i_clk);
        check({h_irq, irq_check[0]}, 2'b11);
        irq_en = 8'hfe;
        repeat (4) @(negedge i_clk);
        check({h_irq, irq_check[0]}, 2'b01);
        irq_pend = 1'b0;
        repeat (4) @(negedge i_clk);
        check(irq_check[0], 1'b0);
        tally_and_finish();
    end
endmodule // optical_link_access_port_bench
